//--- logic/ext_irq_map.svh
// Purpose: Offsets, field positions, reset values and vectors of the pin interrupt block
// Assumes: 3-bit register index on the plain register port, 8-bit data
// Notes:   Definitions only
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// Register offsets
`define SENSE_CONTROL_OFS   3'h0
`define DED_MASK_OFS        3'h1
`define DED_FLAG_OFS        3'h2
`define GROUP_ENABLE_OFS    3'h3
`define GROUP_FLAG_OFS      3'h4
`define CHANGE_MASK_LO_OFS  3'h5
`define CHANGE_MASK_HI_OFS  3'h6

// Field positions and widths
`define SENSE_FIELD_W       2
`define IRQ1_SENSE_LSB      2
`define IRQ0_SENSE_LSB      0
`define SENSE_USED_W        4

// Reset values
`define SENSE_CONTROL_RST   4'h0
`define TWO_BIT_RST         2'h0
`define CHANGE_MASK_RST     16'h0000

// Word addresses of the handler vectors
`define VEC_IRQ_ZERO        16'h0002
`define VEC_IRQ_ONE         16'h0004
`define VEC_GROUP_ZERO      16'h0006
`define VEC_GROUP_ONE       16'h0008
`define VEC_NONE            16'h0000

// Cycles from reset release until edge detectors hold valid history
`define ARM_CYCLES          2'h3

`endif

//--- logic/ext_irq_pkg.sv
// Purpose: Types shared by the pin interrupt block
// Assumes: Nothing beyond the map header
// Notes:   Encoding of the two-bit sense select field
package ext_irq_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_mode_e;

endpackage : ext_irq_pkg

//--- logic/edge_sense.sv
// Purpose: Sample one dedicated interrupt pin and detect edges or a low level
// Assumes: Pin is treated as synchronous to clk_i but still double sampled
// Notes:   Event output is combinational and valid only when armed
`timescale 1ns/1ps
module edge_sense
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Pin and control
  input  wire logic        pin_i,
  input  wire sense_mode_e mode_i,
  input  wire logic        arm_i,
  // Results
  output logic             event_o,
  output logic             low_o
);

  logic [1:0] sync_q;
  logic       prev_q;

  // Two-stage sampler; stage one feeds stage two only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 2'h3;
    end else begin
      sync_q <= {sync_q[0], pin_i};
    end
  end

  // Previous sampled value for the edge compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= sync_q[1];
    end
  end

  // Level seen by the low-level sense path
  assign low_o = ~sync_q[1];

  // Edge decode per sense mode; low level makes no event
  always_comb begin
    event_o = 1'b0;
    if (arm_i) begin
      unique case (mode_i)
        SENSE_LOW:  event_o = 1'b0;
        SENSE_ANY:  event_o = sync_q[1] ^ prev_q;
        SENSE_FALL: event_o = prev_q & ~sync_q[1];
        SENSE_RISE: event_o = ~prev_q & sync_q[1];
      endcase
    end
  end

endmodule : edge_sense

//--- logic/external_pin_interrupts.sv
// Purpose: Dedicated and pin-change interrupt logic with register port
// Assumes: One 250 MHz clock; pins synchronous; CPU acknowledges vectors
// Notes:   Summary of operation follows
//
// Summary of operation
// - Pins raise interrupts even when driven as outputs by the port.
// - Group one watches change pins 15..8, group zero pins 7..0.
// - Per-pin mask registers pick which change pins count; others ignored.
// - Change detection feeds a wake output usable during deep sleep.
// - Each dedicated pin senses any change, falling edge, rising edge or low level.
// - Level mode requests for as long as the pin stays low.
// - Edge detection runs on the clock and needs it running.
// - Low-level detection feeds the wake output without a latched flag.
// - A level gone before start-up wakes the part but raises no request.
// - Upper four bits of the sense control register read as zero.
// - Dedicated request one needs global enable and its mask bit.
// - Sense field of dedicated pin one sits at bits 3 and 2.
// - Pins are sampled before edge detection; pulses over one clock caught.
// - Vectors two words apart: 0x0002, 0x0004, 0x0006 for the first three.
// - Sense code 00 low, 01 any change, 10 falling, 11 rising.
// - Edge and change flags set on events, clear on vector or write one.
// - A dedicated flag reads cleared while its pin senses level.
// - A group request needs its group enable and the global enable.
`timescale 1ns/1ps
`include "ext_irq_map.svh"
module external_pin_interrupts
  import ext_irq_pkg::*;
#(
  parameter int GROUP_W = 8
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [7:0]  rdata_o,
  // Pins
  input  wire logic [1:0]  dedicated_irq_pins_i,
  input  wire logic [15:0] change_detect_pins_i,
  // CPU side
  input  wire logic        global_irq_en_i,
  input  wire logic [3:0]  irq_ack_i,
  output logic      [3:0]  irq_req_o,
  output logic      [15:0] vector_addr_o,
  output logic             wake_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check: registers are one byte per group
  if (GROUP_W != 8) begin : g_bad_width
    $error("GROUP_W must be 8");
  end

  logic [`SENSE_USED_W-1:0] sense_q;
  logic [1:0]               ded_mask_q;
  logic [1:0]               ded_flag_q;
  logic [1:0]               grp_en_q;
  logic [1:0]               grp_flag_q;
  logic [15:0]              chg_mask_q;
  logic [1:0]               arm_cnt_q;
  logic                     arm;
  logic [1:0]               ded_evt;
  logic [1:0]               ded_low;
  logic [1:0]               ded_level;
  logic [1:0]               ded_clr;
  logic [1:0]               grp_clr;
  logic [1:0]               grp_evt;
  logic [15:0]              chg_s1_q;
  logic [15:0]              chg_s2_q;
  logic [15:0]              chg_prev_q;
  logic [15:0]              chg_diff;
  logic [3:0]               req_d;
  logic                     wr_sense;

  //////////////////////////////////////////////////////////////////////////////
  // Arm counter: detectors ignore history until samplers are filled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_cnt_q <= 2'h0;
    end else if (arm_cnt_q != `ARM_CYCLES) begin
      arm_cnt_q <= arm_cnt_q + 2'h1;
    end
  end
  assign arm = (arm_cnt_q == `ARM_CYCLES);

  //////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign wr_sense = we_i && (addr_i == `SENSE_CONTROL_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_q <= `SENSE_CONTROL_RST;
    end else if (wr_sense) begin
      sense_q <= wdata_i[`SENSE_USED_W-1:0];
    end
  end

  // Dedicated mask and group enable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ded_mask_q <= `TWO_BIT_RST;
      grp_en_q   <= `TWO_BIT_RST;
    end else begin
      if (we_i && (addr_i == `DED_MASK_OFS)) begin
        ded_mask_q <= wdata_i[1:0];
      end
      if (we_i && (addr_i == `GROUP_ENABLE_OFS)) begin
        grp_en_q <= wdata_i[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_mask_q <= `CHANGE_MASK_RST;
    end else begin
      if (we_i && (addr_i == `CHANGE_MASK_LO_OFS)) begin
        chg_mask_q[7:0] <= wdata_i;
      end
      if (we_i && (addr_i == `CHANGE_MASK_HI_OFS)) begin
        chg_mask_q[15:8] <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dedicated pins; pins are read directly, so output drive still triggers
  for (genvar i = 0; i < 2; i++) begin : g_ded
    sense_mode_e mode;
    assign mode = sense_mode_e'(sense_q[i*`SENSE_FIELD_W +: `SENSE_FIELD_W]);
    assign ded_level[i] = (mode == SENSE_LOW);
    assign ded_clr[i] = irq_ack_i[i] | (we_i && (addr_i == `DED_FLAG_OFS) && wdata_i[i]);

    edge_sense u_sense (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (dedicated_irq_pins_i[i]),
      .mode_i  (mode),
      .arm_i   (arm),
      .event_o (ded_evt[i]),
      .low_o   (ded_low[i])
    );

    // flag: set beats clear, forced clear in level mode
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ded_flag_q[i] <= 1'b0;
      end else if (ded_level[i]) begin
        ded_flag_q[i] <= 1'b0;
      end else begin
        ded_flag_q[i] <= ded_evt[i] | (ded_flag_q[i] & ~ded_clr[i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Change pins: two-stage sampler, then history for compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_s1_q   <= 16'h0000;
      chg_s2_q   <= 16'h0000;
      chg_prev_q <= 16'h0000;
    end else begin
      chg_s1_q   <= change_detect_pins_i;
      chg_s2_q   <= chg_s1_q;
      chg_prev_q <= chg_s2_q;
    end
  end

  assign chg_diff = (chg_s2_q ^ chg_prev_q) & chg_mask_q & {16{arm}};

  for (genvar g = 0; g < 2; g++) begin : g_grp
    // one OR per group of eight
    assign grp_evt[g] = |chg_diff[g*GROUP_W +: GROUP_W];
    assign grp_clr[g] = irq_ack_i[2+g] | (we_i && (addr_i == `GROUP_FLAG_OFS) && wdata_i[g]);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        grp_flag_q[g] <= 1'b0;
      end else begin
        grp_flag_q[g] <= grp_evt[g] | (grp_flag_q[g] & ~grp_clr[g]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Requests toward the CPU; level requests follow the pin live, so a
  // level that vanished before start-up leaves nothing pending
  always_comb begin
    req_d = 4'h0;
    for (int k = 0; k < 2; k++) begin
      // level or flag, gated by masks
      req_d[k] = global_irq_en_i & ded_mask_q[k] &
                 (ded_level[k] ? (ded_low[k] & arm) : ded_flag_q[k]);
      req_d[2+k] = global_irq_en_i & grp_en_q[k] & grp_flag_q[k];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= 4'h0;
    end else begin
      irq_req_o <= req_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_addr_o <= `VEC_NONE;
    end else if (req_d[0]) begin
      vector_addr_o <= `VEC_IRQ_ZERO;
    end else if (req_d[1]) begin
      vector_addr_o <= `VEC_IRQ_ONE;
    end else if (req_d[2]) begin
      vector_addr_o <= `VEC_GROUP_ZERO;
    end else if (req_d[3]) begin
      vector_addr_o <= `VEC_GROUP_ONE;
    end else begin
      vector_addr_o <= `VEC_NONE;
    end
  end

  // wake: ignores the global enable, since the core sleeps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= |(ded_mask_q & ded_level & ded_low & {2{arm}}) |
                |(ded_mask_q & ded_evt) | |(grp_en_q & grp_evt);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!re_i) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (addr_i)
        `SENSE_CONTROL_OFS:  rdata_o <= {4'h0, sense_q};
        `DED_MASK_OFS:       rdata_o <= {6'h00, ded_mask_q};
        `DED_FLAG_OFS:       rdata_o <= {6'h00, ded_flag_q};
        `GROUP_ENABLE_OFS:   rdata_o <= {6'h00, grp_en_q};
        `GROUP_FLAG_OFS:     rdata_o <= {6'h00, grp_flag_q};
        `CHANGE_MASK_LO_OFS: rdata_o <= chg_mask_q[7:0];
        `CHANGE_MASK_HI_OFS: rdata_o <= chg_mask_q[15:8];
        default:             rdata_o <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_sense_hi_zero;
    @(posedge clk_i) disable iff (rst_i)
    (re_i && addr_i == `SENSE_CONTROL_OFS) |=> (rdata_o[7:4] == 4'h0);
  endproperty
  a_sense_hi_zero: assert property (p_sense_hi_zero)
    else $error("sense control upper bits not zero");

  property p_level_flag_clear;
    @(posedge clk_i) disable iff (rst_i)
    (sense_q[3:2] == 2'b00) ##1 (sense_q[3:2] == 2'b00) |-> (ded_flag_q[1] == 1'b0);
  endproperty
  a_level_flag_clear: assert property (p_level_flag_clear)
    else $error("flag one set in level mode");

  property p_level_holds_req;
    @(posedge clk_i) disable iff (rst_i)
    (arm && sense_q[1:0] == 2'b00 && ded_mask_q[0] && global_irq_en_i && ded_low[0])
      |=> irq_req_o[0];
  endproperty
  a_level_holds_req: assert property (p_level_holds_req)
    else $error("level request missing while pin low");

  property p_req1_gated;
    @(posedge clk_i) disable iff (rst_i)
    irq_req_o[1] |-> $past(global_irq_en_i) && $past(ded_mask_q[1]);
  endproperty
  a_req1_gated: assert property (p_req1_gated)
    else $error("request one without enables");

  property p_w1c_clears;
    @(posedge clk_i) disable iff (rst_i)
    (we_i && addr_i == `GROUP_FLAG_OFS && wdata_i[0] && !grp_evt[0]) |=> !grp_flag_q[0];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("group flag not cleared by write one");

  property p_change_sets_flag;
    @(posedge clk_i) disable iff (rst_i)
    (arm && |((change_detect_pins_i ^ chg_s1_q) & chg_mask_q & 16'h00ff)
      && $stable(chg_mask_q) ##1 $stable(chg_mask_q) ##1 $stable(chg_mask_q))
      |=> (grp_flag_q[0] || $past(grp_clr[0]));
  endproperty
  a_change_sets_flag: assert property (p_change_sets_flag)
    else $error("masked change missed by group zero");

  property p_unmasked_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (chg_mask_q[15:8] == 8'h00 && !grp_flag_q[1]) |=> !grp_flag_q[1];
  endproperty
  a_unmasked_ignored: assert property (p_unmasked_ignored)
    else $error("group one flag set with all pins masked");

  property p_vector_zero;
    @(posedge clk_i) disable iff (rst_i)
    irq_req_o[0] |-> (vector_addr_o == 16'h0002);
  endproperty
  a_vector_zero: assert property (p_vector_zero)
    else $error("wrong vector for dedicated zero");

  property p_group_gated;
    @(posedge clk_i) disable iff (rst_i)
    (!grp_en_q[1] || !global_irq_en_i) |=> !irq_req_o[3];
  endproperty
  a_group_gated: assert property (p_group_gated)
    else $error("group one request without enables");

  property p_rise_detect;
    @(posedge clk_i) disable iff (rst_i)
    (arm && sense_q[1:0] == 2'b11 && dedicated_irq_pins_i[0]
      && !$past(dedicated_irq_pins_i[0]))
      ##1 (sense_q[1:0] == 2'b11) [*2] |=> (ded_flag_q[0] || $past(ded_clr[0]));
  endproperty
  a_rise_detect: assert property (p_rise_detect)
    else $error("rising edge missed on dedicated zero");

endmodule : external_pin_interrupts

//--- testbench/pin_source.sv
// Purpose: Far-side signal source for the dedicated and change pins
// Assumes: Pins change just after a rising clock edge
// Notes:   Levels persist until the next call; no pulse is shorter than a cycle
`timescale 1ns/1ps
module pin_source (
  // Clock
  input  wire logic        clk_i,
  // Pins toward the block
  output logic      [1:0]  dedicated_irq_pins_o,
  output logic      [15:0] change_detect_pins_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Dedicated pins rest high so a low-level mode never fires unasked
  initial begin
    dedicated_irq_pins_o = 2'h3;
    change_detect_pins_o = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // level held on
  // A low level stays until the bench lifts it, covering start-up and instruction end
  task automatic set_ded(input int idx, input logic val);
    @(posedge clk_i);
    dedicated_irq_pins_o[idx] <= val;
  endtask : set_ded

  // pin driven whole cycles
  // Port drives the pin like an output would; each level lasts at least a clock
  task automatic flip_chg(input int idx);
    @(posedge clk_i);
    change_detect_pins_o[idx] <= ~change_detect_pins_o[idx];
  endtask : flip_chg
endmodule : pin_source

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the pin interrupt block
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Edge waits are bounded; expected vectors come from the map header, other expected values are literals
`timescale 1ns/1ps
`include "ext_irq_map.svh"
module testbench;
  import ext_irq_pkg::*;

  // Clock, reset and register port
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        we_i = 1'b0;
  logic        re_i = 1'b0;
  logic [7:0]  rdata_o;
  // Pins and CPU side
  logic [1:0]  dedicated_irq_pins_i;
  logic [15:0] change_detect_pins_i;
  logic        global_irq_en_i = 1'b0;
  logic [3:0]  irq_ack_i = 4'h0;
  logic [3:0]  irq_req_o;
  logic [15:0] vector_addr_o;
  logic        wake_o;
  int          bad_count = 0;
  int          checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  external_pin_interrupts i_external_pin_interrupts (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .dedicated_irq_pins_i(dedicated_irq_pins_i),
    .change_detect_pins_i(change_detect_pins_i), .global_irq_en_i(global_irq_en_i),
    .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .vector_addr_o(vector_addr_o), .wake_o(wake_o));

  pin_source i_pin_source (
    .clk_i(clk_i), .dedicated_irq_pins_o(dedicated_irq_pins_i),
    .change_detect_pins_o(change_detect_pins_i));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Sample one step after the edge so its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    chk(what, 16'(exp), 16'(rdata_o));
  endtask : rd

  task automatic wait_req(input int b);
    for (int i = 0; i < 8 && irq_req_o[b] !== 1'b1; i++) cyc(1);
    chk("request raised", 16'h1, 16'(irq_req_o[b]));
  endtask : wait_req

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_regs;
    for (int a = 0; a < 8; a++) rd("reset value", 3'(a), 8'h00);
    wr(`SENSE_CONTROL_OFS, 8'hff);
    rd("sense reserved bits", `SENSE_CONTROL_OFS, 8'h0f);
    wr(3'h7, 8'hff);
    rd("unmapped index", 3'h7, 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_edge_gate;
    wr(`SENSE_CONTROL_OFS, 8'h0f);
    wr(`DED_MASK_OFS, 8'h01);
    i_pin_source.set_ded(0, 1'b0);
    cyc(4);
    i_pin_source.set_ded(0, 1'b1);
    cyc(6);
    chk("request without global enable", 16'h0, 16'(irq_req_o[0]));
    rd("flag set by edge", `DED_FLAG_OFS, 8'h01);
    @(posedge clk_i);
    global_irq_en_i <= 1'b1;
    wait_req(0);
    chk("vector zero", `VEC_IRQ_ZERO, vector_addr_o);
    @(posedge clk_i);
    irq_ack_i <= 4'h1;
    @(posedge clk_i);
    irq_ack_i <= 4'h0;
    cyc(3);
    chk("request after ack", 16'h0, 16'(irq_req_o[0]));
    $display("test_edge_gate done");
  endtask : test_edge_gate

  // Every sense code on pin one with long pulses, then a two-cycle pulse that must be caught
  task automatic test_modes_one;
    logic [7:0] exp;
    wr(`DED_MASK_OFS, 8'h02);
    for (int m = 0; m < 4; m++) begin
      wr(`SENSE_CONTROL_OFS, 8'(m << `IRQ1_SENSE_LSB));
      i_pin_source.set_ded(1, 1'b0);
      cyc(4);
      if (m == SENSE_LOW) chk("level request", 16'h1, 16'(irq_req_o[1]));
      i_pin_source.set_ded(1, 1'b1);
      cyc(6);
      exp = (m == SENSE_LOW) ? 8'h00 : 8'h02;
      rd("flag one", `DED_FLAG_OFS, exp);
      chk("request one", 16'(exp[1]), 16'(irq_req_o[1]));
      if (exp[1]) chk("vector one", `VEC_IRQ_ONE, vector_addr_o);
      wr(`DED_FLAG_OFS, 8'h02);
      cyc(3);
      chk("request after clear", 16'h0, 16'(irq_req_o[1]));
    end
    wr(`SENSE_CONTROL_OFS, 8'h08);
    i_pin_source.set_ded(1, 1'b0);
    @(posedge clk_i);
    i_pin_source.set_ded(1, 1'b1);
    cyc(4);
    rd("short pulse flag", `DED_FLAG_OFS, 8'h02);
    wr(`DED_FLAG_OFS, 8'h02);
    $display("test_modes_one done");
  endtask : test_modes_one

  task automatic test_groups;
    wr(`GROUP_ENABLE_OFS, 8'h03);
    wr(`CHANGE_MASK_LO_OFS, 8'h08);
    wr(`CHANGE_MASK_HI_OFS, 8'h08);
    i_pin_source.flip_chg(2);
    cyc(6);
    rd("masked pin ignored", `GROUP_FLAG_OFS, 8'h00);
    i_pin_source.flip_chg(11);
    for (int i = 0; i < 6 && wake_o !== 1'b1; i++) cyc(1);
    chk("wake on change", 16'h1, 16'(wake_o));
    wait_req(3);
    chk("vector group one", `VEC_GROUP_ONE, vector_addr_o);
    i_pin_source.flip_chg(3);
    wait_req(2);
    chk("vector group zero", `VEC_GROUP_ZERO, vector_addr_o);
    rd("group flags", `GROUP_FLAG_OFS, 8'h03);
    rd("mask high readback", `CHANGE_MASK_HI_OFS, 8'h08);
    @(posedge clk_i);
    irq_ack_i <= 4'h8;
    @(posedge clk_i);
    irq_ack_i <= 4'h0;
    rd("group flags after ack", `GROUP_FLAG_OFS, 8'h01);
    wr(`GROUP_FLAG_OFS, 8'h03);
    cyc(3);
    chk("group requests cleared", 16'h0, 16'(irq_req_o));
    // event beats a write of one in the same cycle
    i_pin_source.flip_chg(3);
    @(posedge clk_i);
    wr(`GROUP_FLAG_OFS, 8'h01);
    rd("set beats clear", `GROUP_FLAG_OFS, 8'h01);
    wr(`GROUP_FLAG_OFS, 8'h01);
    $display("test_groups done");
  endtask : test_groups

  // Low level wakes without a request when the global enable is off
  task automatic test_level_wake;
    wr(`SENSE_CONTROL_OFS, 8'h00);
    wr(`DED_MASK_OFS, 8'h01);
    @(posedge clk_i);
    global_irq_en_i <= 1'b0;
    i_pin_source.set_ded(0, 1'b0);
    cyc(4);
    chk("level wake", 16'h1, 16'(wake_o));
    chk("no request while gated", 16'h0, 16'(irq_req_o[0]));
    i_pin_source.set_ded(0, 1'b1);
    cyc(4);
    chk("wake released", 16'h0, 16'(wake_o));
    rd("level flag stays clear", `DED_FLAG_OFS, 8'h00);
    $display("test_level_wake done");
  endtask : test_level_wake

  // Mid-run reset: outputs rest at the first edge after release, registers back to zero
  task automatic test_reset;
    wr(`CHANGE_MASK_HI_OFS, 8'hff);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk("requests after reset", 16'h0, 16'(irq_req_o));
    chk("vector after reset", `VEC_NONE, vector_addr_o);
    chk("wake after reset", 16'h0, 16'(wake_o));
    cyc(2);
    rd("mask after reset", `CHANGE_MASK_HI_OFS, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run takes a few hundred cycles; this limit only cuts a hang
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(3);
    test_regs;
    test_edge_gate;
    test_modes_one;
    test_groups;
    test_level_wake;
    test_reset;
    tally_and_finish;
  end
endmodule : testbench
